/* File: verilog/iamt_top.sv */
// Second address match and master bit timing with Avalon-MM registers
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module iamt_top import iamt_pkg::*; (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Controller core
   input wire logic i_master_mode,
   input wire logic i_clk_run,
   input wire logic i_slave_stretch_off,
   input wire logic [6:0] i_rx_addr,
   input wire logic i_rx_addr_valid,
   output logic o_addr2_match,
   output logic [6:0] o_match_addr,
   output logic o_data_change,
   output logic o_stretch,
   // Serial clock pin
   input wire logic i_scl_in,
   output logic o_scl_o,
   output logic o_scl_oe
);
   iamt_cfg_if cfg ();

   logic [31:0] addr2_reg;
   logic [31:0] addr2_next;
   logic [31:0] timing_reg;
   logic [31:0] timing_next;
   logic [31:0] rdata_next;
   logic wait_next;
   logic wr_commit;

   iamt_state_t state_reg;
   iamt_state_t state_next;
   logic [7:0] tcnt_reg;
   logic [7:0] tcnt_next;
   logic scl_prev_reg;
   logic scl_fall;
   logic tick;
   logic restart;
   logic delay_next;
   logic oe_next;
   logic stretch_next;
   logic change_next;
   logic leave_now;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [31:0] wm);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
      return (old & ~m) | (wd & m);
   endfunction

   function automatic logic is_delay(input iamt_state_t s);
      return (s == IAMT_HOLD) || (s == IAMT_SETUP);
   endfunction

   // Register fields to sub-blocks; edits under enable are not guarded
   assign cfg.en = addr2_reg[IAMT_EN_BIT];
   assign cfg.mask = addr2_reg[IAMT_MASK_LSB +: 3];
   assign cfg.val = addr2_reg[IAMT_VAL_LSB +: 7];
   assign cfg.timing_prescaler = timing_reg[IAMT_PSC_LSB +: 4];
   assign cfg.setup = timing_reg[IAMT_SETUP_LSB +: 4];
   assign cfg.hold = timing_reg[IAMT_HOLD_LSB +: 4];
   assign cfg.high = timing_reg[IAMT_HIGH_LSB +: 8];
   assign cfg.low = timing_reg[IAMT_LOW_LSB +: 8];

   iamt_match u_match (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .cfg(cfg.match),
      .i_rx_addr(i_rx_addr),
      .i_rx_addr_valid(i_rx_addr_valid),
      .o_match(o_addr2_match),
      .o_match_addr(o_match_addr)
   );

   iamt_presc u_presc (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_restart(restart),
      .cfg(cfg.timer),
      .o_tick(tick)
   );

   // Bus slave: one wait cycle; read data loads as it ends, a write lands one edge later
   always_comb begin
      wait_next = !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      wr_commit = i_avs_write && !o_avs_waitrequest;
      addr2_next = addr2_reg;
      timing_next = timing_reg;
      rdata_next = o_avs_readdata;
      if (wr_commit && i_avs_address == IAMT_OFS_ADDR2) begin
         addr2_next = be_merge(addr2_reg, i_avs_writedata, i_avs_byteenable, IAMT_ADDR2_WMASK);
      end
      if (wr_commit && i_avs_address == IAMT_OFS_TIMING) begin
         timing_next = be_merge(timing_reg, i_avs_writedata, i_avs_byteenable,
                                IAMT_TIMING_WMASK);
      end
      if (i_avs_read && o_avs_waitrequest) begin
         case (i_avs_address)
            IAMT_OFS_ADDR2: begin
               rdata_next = addr2_reg;
            end
            IAMT_OFS_TIMING: begin
               rdata_next = timing_reg;
            end
            IAMT_OFS_STATUS: begin
               rdata_next = 32'h0000_0000;
               rdata_next[6:0] = o_match_addr;
               rdata_next[IAMT_ST_OE_BIT] = o_scl_oe;
               rdata_next[IAMT_ST_STR_BIT] = o_stretch;
               rdata_next[IAMT_ST_BUSY_BIT] = (state_reg != IAMT_IDLE);
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr2_reg <= IAMT_ADDR2_RST;
         timing_reg <= IAMT_TIMING_RST;
         o_avs_readdata <= 32'h0000_0000;
         o_avs_waitrequest <= 1'b1;
      end else begin
         addr2_reg <= addr2_next;
         timing_reg <= timing_next;
         o_avs_readdata <= rdata_next;
         o_avs_waitrequest <= wait_next;
      end
   end

   // Serial clock sequencer
   assign scl_fall = scl_prev_reg && !i_scl_in;
   assign restart = (state_next != state_reg);

   always_comb begin
      state_next = state_reg;
      leave_now = 1'b0;
      case (state_reg)
         IAMT_IDLE: begin
            if (i_master_mode ? i_clk_run : scl_fall) begin
               state_next = (cfg.hold == 4'h0) ? IAMT_SETUP : IAMT_HOLD;
            end
         end
         IAMT_HOLD: begin
            // Zero hold means no delay at all
            leave_now = (cfg.hold == 4'h0) || (tick && (tcnt_reg + 8'h01) == {4'h0, cfg.hold});
            if (leave_now) begin
               state_next = IAMT_SETUP;
            end
         end
         IAMT_SETUP: begin
            leave_now = tick && (tcnt_reg == {4'h0, cfg.setup});
            if (leave_now) begin
               state_next = i_master_mode ? IAMT_LOW : IAMT_IDLE;
            end
         end
         IAMT_LOW: begin
            leave_now = tick && (tcnt_reg == cfg.low);
            if (!i_master_mode) begin
               state_next = IAMT_IDLE;
            end else if (leave_now) begin
               state_next = IAMT_HIGH;
            end
         end
         IAMT_HIGH: begin
            leave_now = tick && (tcnt_reg == cfg.high);
            if (!i_master_mode) begin
               state_next = IAMT_IDLE;
            end else if (leave_now) begin
               state_next = i_clk_run ? (cfg.hold == 4'h0 ? IAMT_SETUP : IAMT_HOLD) : IAMT_IDLE;
            end
         end
         default: begin
            state_next = IAMT_IDLE;
         end
      endcase
      if (state_next != state_reg) begin
         tcnt_next = 8'h00;
      end else if (tick) begin
         tcnt_next = tcnt_reg + 8'h01;
      end else begin
         tcnt_next = tcnt_reg;
      end
      // Slave may only stretch; it never shapes the high or low time
      delay_next = is_delay(state_next) && (i_master_mode || !i_slave_stretch_off);
      oe_next = delay_next || (i_master_mode && state_next == IAMT_LOW);
      stretch_next = delay_next;
      change_next = (state_reg != IAMT_SETUP) && (state_next == IAMT_SETUP);
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg <= IAMT_IDLE;
         tcnt_reg <= 8'h00;
         scl_prev_reg <= 1'b1;
         o_scl_o <= 1'b0;
         o_scl_oe <= 1'b0;
         o_stretch <= 1'b0;
         o_data_change <= 1'b0;
      end else begin
         state_reg <= state_next;
         tcnt_reg <= tcnt_next;
         scl_prev_reg <= i_scl_in;
         o_scl_o <= 1'b0;
         o_scl_oe <= oe_next;
         o_stretch <= stretch_next;
         o_data_change <= change_next;
      end
   end

   // Checking helpers: cycles in state and since the last tick
   logic [15:0] cyc_reg;
   logic [15:0] cyc_next;
   logic [3:0] gap_reg;
   logic [3:0] gap_next;

   function automatic logic [15:0] span(input logic [8:0] ticks, input logic [3:0] timing_prescaler);
      logic [15:0] p;
      p = 16'(ticks) * 16'({1'b0, timing_prescaler} + 5'h01);
      return (ticks == 9'h000) ? 16'h0000 : p - 16'h0001;
   endfunction

   always_comb begin
      cyc_next = restart ? 16'h0000 : cyc_reg + 16'h0001;
      gap_next = (restart || tick) ? 4'h0 : gap_reg + 4'h1;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cyc_reg <= 16'h0000;
         gap_reg <= 4'h0;
      end else begin
         cyc_reg <= cyc_next;
         gap_reg <= gap_next;
      end
   end

   a_tick_period: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      tick |-> gap_reg == cfg.timing_prescaler)
      else $error("base tick spacing wrong");
   a_setup_length: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == IAMT_SETUP && restart |-> cyc_reg == span({5'h00, cfg.setup} + 9'h001, cfg.timing_prescaler))
      else $error("setup delay length wrong");
   a_hold_length: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == IAMT_HOLD && restart |-> cyc_reg == span({5'h00, cfg.hold}, cfg.timing_prescaler))
      else $error("hold delay length wrong");
   a_high_length: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == IAMT_HIGH && restart && i_master_mode
      |-> cyc_reg == span({1'b0, cfg.high} + 9'h001, cfg.timing_prescaler))
      else $error("clock high length wrong");
   a_low_length: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == IAMT_LOW && restart && i_master_mode
      |-> cyc_reg == span({1'b0, cfg.low} + 9'h001, cfg.timing_prescaler))
      else $error("clock low length wrong");
   a_delay_stretch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      is_delay(state_next) && (i_master_mode || !i_slave_stretch_off) |=> o_scl_oe && o_stretch)
      else $error("clock not held low during delay");
   a_slave_no_clock: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_master_mode |=> state_reg != IAMT_LOW && state_reg != IAMT_HIGH)
      else $error("slave mode shaped the clock");
   a_data_after_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_data_change |-> state_reg == IAMT_SETUP && ($past(state_reg) == IAMT_HOLD || cfg.hold == 4'h0))
      else $error("data change outside hold end");
   a_bus_answer: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not after one wait cycle");

   c_master_cycle: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      state_reg == IAMT_HIGH ##1 state_reg == IAMT_HOLD);
   c_slave_stretch: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_master_mode && o_stretch);
   c_reg_write: cover property (@(posedge i_mclk) disable iff (i_sys_rst) wr_commit);
endmodule
`default_nettype wire

/* File: verilog/iamt_pkg.sv */
// Constants and types shared by the second-address and bit-timing block
package iamt_pkg;
   // Register byte offsets
   localparam logic [4:0] IAMT_OFS_ADDR2 = 5'h0c;
   localparam logic [4:0] IAMT_OFS_TIMING = 5'h10;
   localparam logic [4:0] IAMT_OFS_STATUS = 5'h1c;
   // Reset values and writable bits
   localparam logic [31:0] IAMT_ADDR2_RST = 32'h0000_0000;
   localparam logic [31:0] IAMT_TIMING_RST = 32'h0000_0000;
   localparam logic [31:0] IAMT_ADDR2_WMASK = 32'h0000_87fe;
   localparam logic [31:0] IAMT_TIMING_WMASK = 32'hf0ff_ffff;
   // Field positions, second address register
   localparam int IAMT_EN_BIT = 15;
   localparam int IAMT_MASK_LSB = 8;
   localparam int IAMT_VAL_LSB = 1;
   // Field positions, timing register
   localparam int IAMT_PSC_LSB = 28;
   localparam int IAMT_SETUP_LSB = 20;
   localparam int IAMT_HOLD_LSB = 16;
   localparam int IAMT_HIGH_LSB = 8;
   localparam int IAMT_LOW_LSB = 0;
   // Field positions, status register
   localparam int IAMT_ST_OE_BIT = 8;
   localparam int IAMT_ST_STR_BIT = 9;
   localparam int IAMT_ST_BUSY_BIT = 10;
   // Reserved address groups, upper four address bits
   localparam logic [3:0] IAMT_RSVD_LO = 4'h0;
   localparam logic [3:0] IAMT_RSVD_HI = 4'hf;
   localparam logic [2:0] IAMT_MASK_ALL = 3'h7;
   // Serial clock sequencer states
   typedef enum logic [2:0] {
      IAMT_IDLE,
      IAMT_HOLD,
      IAMT_SETUP,
      IAMT_LOW,
      IAMT_HIGH
   } iamt_state_t;
endpackage

/* File: verilog/iamt_cfg_if.sv */
// Configuration fields passed from the register file to the sub-blocks
`timescale 1ns/1ns
`default_nettype none
interface iamt_cfg_if;
   logic en;
   logic [2:0] mask;
   logic [6:0] val;
   logic [3:0] timing_prescaler;
   logic [3:0] setup;
   logic [3:0] hold;
   logic [7:0] high;
   logic [7:0] low;
   modport regs (output en, mask, val, timing_prescaler, setup, hold, high, low);
   modport match (input en, mask, val);
   modport timer (input timing_prescaler);
endinterface
`default_nettype wire

/* File: verilog/iamt_presc.sv */
// Prescaler that turns the kernel clock into one-cycle base ticks
`timescale 1ns/1ns
`default_nettype none
module iamt_presc import iamt_pkg::*; (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_restart,
   iamt_cfg_if.timer cfg,
   // Tick
   output logic o_tick
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;

   assign o_tick = (cnt_reg == cfg.timing_prescaler);

   always_comb begin
      if (i_restart || o_tick) begin
         cnt_next = 4'h0;
      end else begin
         cnt_next = cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/iamt_match.sv */
// Second slave address comparator with mask and reserved-group refusal
`timescale 1ns/1ns
`default_nettype none
module iamt_match import iamt_pkg::*; (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Configuration
   iamt_cfg_if.match cfg,
   // Received address
   input wire logic [6:0] i_rx_addr,
   input wire logic i_rx_addr_valid,
   // Match result
   output logic o_match,
   output logic [6:0] o_match_addr
);
   logic match_next;
   logic [6:0] maddr_next;

   function automatic logic is_rsvd(input logic [6:0] a);
      return (a[6:3] == IAMT_RSVD_LO) || (a[6:3] == IAMT_RSVD_HI);
   endfunction

   function automatic logic addr_hit(input logic en, input logic [2:0] mask,
                                     input logic [6:0] val, input logic [6:0] rx);
      logic [6:0] care;
      care = 7'h7f << mask;
      if (!en) begin
         return 1'b0;
      end
      if ((mask != 3'h0) && is_rsvd(rx)) begin
         return 1'b0;
      end
      return ((val ^ rx) & care) == 7'h00;
   endfunction

   always_comb begin
      match_next = i_rx_addr_valid && addr_hit(cfg.en, cfg.mask, cfg.val, i_rx_addr);
      maddr_next = match_next ? i_rx_addr : o_match_addr;
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_match <= 1'b0;
         o_match_addr <= 7'h00;
      end else begin
         o_match <= match_next;
         o_match_addr <= maddr_next;
      end
   end

   a_disabled_none: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_rx_addr_valid && !cfg.en |=> !o_match)
      else $error("match while second address disabled");
   a_exact_compare: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_rx_addr_valid && cfg.en && cfg.mask == 3'h0 |=> o_match == ($past(i_rx_addr) == $past(cfg.val)))
      else $error("unmasked compare wrong");
   a_masked_compare: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_rx_addr_valid && cfg.en && cfg.mask != 3'h0 && cfg.mask != IAMT_MASK_ALL
      && ((i_rx_addr ^ cfg.val) >> cfg.mask) != 7'h00 |=> !o_match)
      else $error("masked compare accepted differing bits");
   a_mask_all_acks: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_rx_addr_valid && cfg.en && cfg.mask == IAMT_MASK_ALL && !is_rsvd(i_rx_addr) |=> o_match)
      else $error("full mask missed an address");
   a_reserved_nack: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_rx_addr_valid && cfg.mask != 3'h0 && is_rsvd(i_rx_addr) |=> !o_match)
      else $error("reserved address acknowledged");
   a_match_report: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_match |-> o_match_addr == $past(i_rx_addr) && $past(i_rx_addr_valid))
      else $error("match event without its address");
   c_addr_match: cover property (@(posedge i_mclk) disable iff (i_sys_rst) o_match);
endmodule
`default_nettype wire

/* File: verif/iamt_bus_peer.sv */
// Behavioural peer on the shared two-wire bus that pulls the serial clock line
`timescale 1ns/1ns
`default_nettype none
module iamt_bus_peer (
   // Clock
   input wire logic i_mclk,
   // Shared serial clock line
   input wire logic i_dut_scl_oe,
   output logic o_scl
);
   logic peer_oe = 1'b0;
   // Pull-up on the line, so it floats high once nobody pulls it
   assign o_scl = ~(peer_oe | i_dut_scl_oe);
   // Low for low_cyc cycles; a slow peer just passes a larger count
   task automatic clock_pulse(input int low_cyc);
      int n;
      n = 0;
      peer_oe <= 1'b1;
      repeat (low_cyc) @(posedge i_mclk);
      peer_oe <= 1'b0;
      // A stretched line holds the peer off before its next high time
      while (o_scl !== 1'b1 && n < 1000) begin
         @(posedge i_mclk);
         n++;
      end
   endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the second-address match and bit-timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) fail_msg($sformatf("%0h exp %0h", g, e)); end
module tb import iamt_pkg::*;;
   localparam logic [31:0] TCFG [3] = '{32'h1012_0302, 32'h0000_0000, 32'h2031_0104};
   logic i_mclk = 1'b0;
   logic i_sys_rst;
   logic [4:0] i_avs_address;
   logic i_avs_read, i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0] i_avs_byteenable;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic i_master_mode, i_clk_run, i_slave_stretch_off;
   logic [6:0] i_rx_addr;
   logic i_rx_addr_valid;
   logic o_addr2_match;
   logic [6:0] o_match_addr;
   logic o_data_change, o_stretch, o_scl_o, o_scl_oe;
   wire logic scl_line;
   int n_fail = 0;
   int checked = 0;

   always #4 i_mclk = ~i_mclk;

   iamt_top uut (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_master_mode(i_master_mode), .i_clk_run(i_clk_run),
      .i_slave_stretch_off(i_slave_stretch_off), .i_rx_addr(i_rx_addr),
      .i_rx_addr_valid(i_rx_addr_valid), .o_addr2_match(o_addr2_match),
      .o_match_addr(o_match_addr), .o_data_change(o_data_change), .o_stretch(o_stretch),
      .i_scl_in(scl_line), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe)
   );

   iamt_bus_peer peer (
      .i_mclk(i_mclk),
      .i_dut_scl_oe(o_scl_oe),
      .o_scl(scl_line)
   );

   task automatic fail_msg(input string s);
      n_fail++;
      $display("[ERR] %0t %s", $time, s);
   endtask

   task automatic test_done();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Expected match worked out independently of the design
   function automatic logic exp_match(input logic e, input logic [2:0] m,
                                      input logic [6:0] v, input logic [6:0] r);
      logic rsvd;
      rsvd = (r[6:3] == 4'h0) || (r[6:3] == 4'hf);
      if (!e) return 1'b0;
      if (m == 3'h0) return r == v;
      if (m == 3'h7) return !rsvd;
      return ((r >> m) == (v >> m)) && !rsvd;
   endfunction

   // Request held until waitrequest is sampled low, then released
   task automatic xfer(input logic wr_n, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      i_avs_write <= wr_n;
      i_avs_read <= ~wr_n;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 100);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (n >= 100) begin
         fail_msg("bus hang");
         test_done();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      xfer(1'b1, a, d, be, q);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 4'hf, q);
      `CHK(q, e)
   endtask

   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (o_scl_oe !== v && n < 2000) begin
         @(posedge i_mclk);
         n++;
      end
      if (n >= 2000) begin
         fail_msg("clock line wait");
         test_done();
      end
   endtask

   initial begin
      #600000;
      fail_msg("watchdog");
      test_done();
   end

   initial begin
      logic [31:0] c;
      logic [6:0] v, r, last;
      logic [6:0] rl [8];
      logic e;
      int lo, hi, st, dc, t;
      i_sys_rst = 1'b1;
      {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata, i_avs_byteenable} = '0;
      {i_master_mode, i_clk_run, i_slave_stretch_off, i_rx_addr, i_rx_addr_valid} = '0;
      c = 32'h0;
      last = 7'h0;
      repeat (8) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      `CHK(o_avs_waitrequest, 1'b1)
      rd_chk(IAMT_OFS_ADDR2, 32'h0);
      rd_chk(IAMT_OFS_TIMING, 32'h0);
      wr(IAMT_OFS_TIMING, 32'hffff_ffff, 4'h3);
      rd_chk(IAMT_OFS_TIMING, 32'h0000_ffff);
      wr(IAMT_OFS_TIMING, 32'hffff_ffff, 4'hf);
      rd_chk(IAMT_OFS_TIMING, 32'hf0ff_ffff);
      wr(IAMT_OFS_ADDR2, 32'hffff_ffff, 4'hf);
      rd_chk(IAMT_OFS_ADDR2, 32'h0000_87fe);
      c = 32'h0000_87fe;
      wr(5'h04, 32'hffff_ffff, 4'hf);
      rd_chk(5'h04, 32'h0);
      // Third pass leaves the enable clear
      for (int p = 0; p < 3; p++) begin
         v = (p == 1) ? 7'h7d : 7'h35;
         e = (p != 2);
         rl = '{v, v ^ 7'h01, v ^ 7'h02, v ^ 7'h04, v ^ 7'h08, v ^ 7'h40,
                7'h03, 7'h7a};
         for (int m = 0; m < 8; m++) begin
            wr(IAMT_OFS_ADDR2, c & 32'hffff_7fff, 4'hf);
            c = {16'h0, e, 4'h0, 3'(m), v, 1'b0};
            wr(IAMT_OFS_ADDR2, c, 4'hf);
            for (int k = 0; k < 8; k++) begin
               r = rl[k];
               @(posedge i_mclk);
               i_rx_addr <= r;
               i_rx_addr_valid <= 1'b1;
               @(posedge i_mclk);
               i_rx_addr_valid <= 1'b0;
               @(posedge i_mclk);
               `CHK(o_addr2_match, exp_match(e, 3'(m), v, r))
               if (exp_match(e, 3'(m), v, r)) begin
                  last = r;
                  `CHK(o_match_addr, r)
               end
            end
         end
      end
      // Each config is one full low phase and one high phase
      for (int i = 0; i < 3; i++) begin
         c = TCFG[i];
         t = c[31:28] + 1;
         wr(IAMT_OFS_TIMING, c, 4'hf);
         @(posedge i_mclk);
         i_master_mode <= 1'b1;
         i_clk_run <= 1'b1;
         wait_oe(1'b1);
         lo = 0;
         st = 0;
         dc = 0;
         while (o_scl_oe === 1'b1 && lo < 5000) begin
            lo++;
            st += int'(o_stretch === 1'b1);
            dc += int'(o_data_change === 1'b1);
            @(posedge i_mclk);
         end
         hi = 0;
         while (o_scl_oe === 1'b0 && hi < 5000) begin
            hi++;
            @(posedge i_mclk);
         end
         i_master_mode <= 1'b0;
         i_clk_run <= 1'b0;
         `CHK(lo, (c[19:16] + c[23:20] + c[7:0] + 2) * t)
         `CHK(hi, (c[15:8] + 1) * t)
         `CHK(st, (c[19:16] + c[23:20] + 1) * t)
         `CHK(dc, 1)
         // Delay already begun still runs out as a slave stretch
         wait_oe(1'b0);
         repeat (3) @(posedge i_mclk);
         `CHK(o_scl_oe, 1'b0)
         `CHK(o_scl_o, 1'b0)
      end
      rd_chk(IAMT_OFS_STATUS, {25'h0, last});
      // Slave mode: high and low fields must not drive the line
      wr(IAMT_OFS_TIMING, 32'h1012_0302, 4'hf);
      for (int s = 0; s < 2; s++) begin
         @(posedge i_mclk);
         i_clk_run <= 1'b1;
         i_slave_stretch_off <= 1'(s);
         lo = 0;
         st = 0;
         repeat (20) begin
            @(posedge i_mclk);
            lo += int'(o_scl_oe === 1'b1);
         end
         `CHK(lo, 0)
         fork
            peer.clock_pulse(3);
            repeat (40) begin
               @(posedge i_mclk);
               lo += int'(o_scl_oe === 1'b1);
               st += int'(o_stretch === 1'b1);
            end
         join
         `CHK(lo, (s == 1) ? 0 : (2 + 1 + 1) * 2)
         `CHK(st, (s == 1) ? 0 : (2 + 1 + 1) * 2)
      end
      test_done();
   end
endmodule
`default_nettype wire
